// File: design/vsd_memory_decoder.v
// Address and modifier decoder for two quads of byte-wide sockets.
// Assumes bus inputs and straps synchronous to clock_i; strap = 1 when fitted.
`timescale 1ns/10ps

`include "vsd_map.vh"

module vsd_memory_decoder (
  input  wire        clock_i,
  input  wire        arst_n_i,
  // Memory cycle request
  input  wire [31:0] vme_addr_i,
  input  wire [5:0]  vme_am_i,
  input  wire        vme_strobe_i,
  // Straps
  input  wire [9:0]  eprom_base_low_straps_i,
  input  wire [7:0]  eprom_base_high_straps_i,
  input  wire [9:0]  ram_base_low_straps_i,
  input  wire [7:0]  ram_base_high_straps_i,
  input  wire [2:0]  eprom_size_straps_i,
  input  wire [2:0]  ram_size_straps_i,
  input  wire [1:0]  modifier_eprom_enable_straps_i,
  input  wire [1:0]  eprom_quad_enable_straps_i,
  input  wire [1:0]  ram_quad_enable_straps_i,
  // Socket side
  output reg  [7:0]  socket_select_n_o,
  output reg         mem_hit_o,
  output reg         other_inhibit_o,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [3:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o
);

  // ****************************************
  // Decode helpers
  // ****************************************

  // Size code from straps; a fitted strap reads as one and clears its code bit
  function [2:0] size_code;
    input [2:0] fit;
    begin
      size_code = ~fit;
    end
  endfunction

  // Base compare above the region; lines inside the region are not compared
  function base_match;
    input [31:0] a;
    input [9:0]  lo_fit;
    input [7:0]  hi_fit;
    input [2:0]  code;
    input        ext;
    integer      i;
    reg          m;
    begin
      m = 1'b1;
      for (i = `VSD_BASE_LSB; i <= `VSD_STD_MSB; i = i + 1) begin
        if (i >= `VSD_BASE_LSB + code && a[i] == lo_fit[i - `VSD_BASE_LSB]) begin
          m = 1'b0;  // fitted strap wants the line low
        end
      end
      for (i = `VSD_HIGH_LSB; i < 32; i = i + 1) begin
        if (ext && a[i] == hi_fit[i - `VSD_HIGH_LSB]) begin
          m = 1'b0;
        end
      end
      base_match = m;
    end
  endfunction

  // Quad index inside an eight-device region
  function quad_of;
    input [31:0] a;
    input [2:0]  code;
    begin
      quad_of = a[`VSD_QUAD_LSB + code];
    end
  endfunction

  // One-hot active-low select for a socket group and lane
  function [7:0] sel_of;
    input       grp_b;
    input [1:0] lane;
    reg   [7:0] s;
    begin
      s = 8'hFF;
      s[{grp_b, lane}] = 1'b0;
      sel_of = s;
    end
  endfunction

  // ****************************************
  // Transfer classification
  // ****************************************
  wire am_std;
  wire am_ext;
  wire am_rom2;
  wire am_rom1;
  wire [2:0] rom_code;
  wire [2:0] ram_code;
  wire rom_code_ok;
  wire ram_code_ok;

  // Standard and extended modifier sets
  assign am_std = (vme_am_i == `VSD_AM_STD_0) || (vme_am_i == `VSD_AM_STD_1) ||
                  (vme_am_i == `VSD_AM_STD_2) || (vme_am_i == `VSD_AM_STD_3);
  assign am_ext = (vme_am_i == `VSD_AM_EXT_0) || (vme_am_i == `VSD_AM_EXT_1) ||
                  (vme_am_i == `VSD_AM_EXT_2) || (vme_am_i == `VSD_AM_EXT_3);

  // Dedicated EPROM modifiers, each behind its own strap
  assign am_rom2 = (vme_am_i == `VSD_AM_ROM_Q2) && modifier_eprom_enable_straps_i[0]
                   && eprom_quad_enable_straps_i[1];
  assign am_rom1 = (vme_am_i == `VSD_AM_ROM_Q1) && modifier_eprom_enable_straps_i[1]
                   && eprom_quad_enable_straps_i[0];

  // Codes 6 and 7 have no part; such a region never decodes by address, though an EPROM region still answers the dedicated EPROM modifiers
  assign rom_code    = size_code(eprom_size_straps_i);
  assign ram_code    = size_code(ram_size_straps_i);
  assign rom_code_ok = rom_code <= `VSD_SIZE_MAX;
  assign ram_code_ok = ram_code <= `VSD_SIZE_MAX;

  // ****************************************
  // Region decode
  // ****************************************
  wire rom_q;
  wire ram_q;
  wire rom_base_ok;
  wire ram_base_ok;
  wire all_ram;
  wire rom_hit;
  wire ram_hit;
  wire mod_hit;

  assign rom_q = quad_of(vme_addr_i, rom_code);
  assign ram_q = quad_of(vme_addr_i, ram_code);
  assign rom_base_ok = base_match(vme_addr_i, eprom_base_low_straps_i,
                                  eprom_base_high_straps_i, rom_code, am_ext);
  assign ram_base_ok = base_match(vme_addr_i, ram_base_low_straps_i,
                                  ram_base_high_straps_i, ram_code, am_ext);

  // Both quads RAM: the EPROM base straps play no part
  assign all_ram = (ram_quad_enable_straps_i == 2'h3);

  // RAM window; quad 2 follows quad 1 at four device sizes
  assign ram_hit = (am_std || am_ext) && ram_code_ok && ram_base_ok &&
                   ram_quad_enable_straps_i[ram_q];

  // EPROM window, independent of RAM when mixed
  assign rom_hit = (am_std || am_ext) && rom_code_ok && rom_base_ok && !all_ram &&
                   eprom_quad_enable_straps_i[rom_q];

  // Modifier path bypasses every base compare
  assign mod_hit = am_rom1 || am_rom2;

  // ****************************************
  // Socket select
  // ****************************************
  // RAM quad 1 and EPROM quad 2 share group A (selects 1-4);
  // RAM quad 2 and EPROM quad 1 share group B (selects 5-8).
  reg [7:0] next_select_n;
  reg       next_hit;
  reg       next_mod;
  reg       dec_en;

  // RAM wins an overlap; overlapping bases are a strap error anyway
  always @* begin
    next_select_n = 8'hFF;
    next_hit      = 1'b0;
    next_mod      = 1'b0;
    if (vme_strobe_i && dec_en) begin
      if (mod_hit) begin
        next_select_n = sel_of(am_rom1, vme_addr_i[1:0]);
        next_hit      = 1'b1;
        next_mod      = 1'b1;
      end else if (ram_hit) begin
        next_select_n = sel_of(ram_q, vme_addr_i[1:0]);
        next_hit      = 1'b1;
      end else if (rom_hit) begin
        next_select_n = sel_of(!rom_q, vme_addr_i[1:0]);
        next_hit      = 1'b1;
      end
    end
  end

  // Registered so selects never glitch while address settles
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      socket_select_n_o <= 8'hFF;
      mem_hit_o         <= 1'b0;
      other_inhibit_o   <= 1'b0;
    end else begin
      socket_select_n_o <= next_select_n;
      mem_hit_o         <= next_hit;
      other_inhibit_o   <= next_mod;
    end
  end

  // ****************************************
  // Status capture
  // ****************************************
  reg [7:0]  last_select_n;
  reg        last_mod;
  reg        last_miss;
  reg        strobe_d;
  reg [15:0] hit_count;
  wire       cnt_clear;

  // One capture per strobe, at its first cycle
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      strobe_d      <= 1'b0;
      last_select_n <= 8'hFF;
      last_mod      <= 1'b0;
      last_miss     <= 1'b0;
    end else begin
      strobe_d <= vme_strobe_i;
      if (vme_strobe_i && !strobe_d) begin
        last_select_n <= next_select_n;
        last_mod      <= next_mod;
        last_miss     <= !next_hit;
      end
    end
  end

  // Hit counter; a clear and a new hit in the same cycle load a count of one
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hit_count <= 16'h0000;
    end else if (vme_strobe_i && !strobe_d && next_hit) begin
      hit_count <= cnt_clear ? 16'h0001 : hit_count + 16'h0001;
    end else if (cnt_clear) begin
      hit_count <= 16'h0000;
    end
  end

  // ****************************************
  // Wishbone slave
  // ****************************************
  wire wb_req;
  wire wb_wr;

  assign wb_req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr     = wb_req && wb_we_i && wb_sel_i[0];
  assign cnt_clear = wb_wr && (wb_adr_i == `VSD_REG_COUNT);

  // Decode enable; off forces every select inactive
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dec_en <= `VSD_CTRL_RESET;
    end else if (wb_wr && wb_adr_i == `VSD_REG_CTRL) begin
      dec_en <= wb_dat_i[`VSD_CTRL_EN];
    end
  end

  // One wait state; unmapped offsets read zero and still ack
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h00000000;
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          `VSD_REG_CTRL: begin
            wb_dat_o <= {31'h00000000, dec_en};
          end
          `VSD_REG_STATUS: begin
            wb_dat_o <= {16'h0000, ram_code, rom_code, last_miss, last_mod,
                         ~last_select_n};
          end
          `VSD_REG_COUNT: begin
            wb_dat_o <= {16'h0000, hit_count};
          end
          default: begin
            wb_dat_o <= 32'h00000000;
          end
        endcase
      end
    end
  end

endmodule

// File: design/vsd_map.vh
// Constants for the socket memory decoder.
// Assumes inclusion by bare name from design files.
`ifndef VSD_MAP_VH
`define VSD_MAP_VH

// ****************************************
// Address modifier codes
// ****************************************
`define VSD_AM_STD_0     6'h39
`define VSD_AM_STD_1     6'h3A
`define VSD_AM_STD_2     6'h3D
`define VSD_AM_STD_3     6'h3E
`define VSD_AM_EXT_0     6'h09
`define VSD_AM_EXT_1     6'h0A
`define VSD_AM_EXT_2     6'h0D
`define VSD_AM_EXT_3     6'h0E
`define VSD_AM_ROM_Q2    6'h1E
`define VSD_AM_ROM_Q1    6'h16

// ****************************************
// Address field layout
// ****************************************
`define VSD_BASE_LSB     14
`define VSD_STD_MSB      23
`define VSD_HIGH_LSB     24
`define VSD_QUAD_LSB     13
`define VSD_SIZE_MAX     3'h5

// ****************************************
// Register offsets, fields, resets
// ****************************************
`define VSD_REG_CTRL     4'h0
`define VSD_REG_STATUS   4'h4
`define VSD_REG_COUNT    4'h8
`define VSD_CTRL_EN      0
`define VSD_CTRL_RESET   1'h1

`endif

// File: tb/vsd_decoder_checker.sv
// Checker for the socket memory decoder, seeing top-level ports only.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/10ps
module vsd_decoder_checker (
  input wire        clock_i,
  input wire        arst_n_i,
  input wire [31:0] vme_addr_i,
  input wire [5:0]  vme_am_i,
  input wire        vme_strobe_i,
  input wire [1:0]  modifier_eprom_enable_straps_i,
  input wire [1:0]  eprom_quad_enable_straps_i,
  input wire [7:0]  socket_select_n_o,
  input wire        mem_hit_o,
  input wire        other_inhibit_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  // Short names for the strap and modifier conditions
  wire [1:0] men = modifier_eprom_enable_straps_i;
  wire [1:0] rq  = eprom_quad_enable_straps_i;
  wire       m16 = vme_strobe_i && vme_am_i == 6'h16;
  wire       m1e = vme_strobe_i && vme_am_i == 6'h1E;
  wire       bad = vme_strobe_i && !(vme_am_i inside {6'h39, 6'h3A, 6'h3D, 6'h3E,
                   6'h09, 6'h0A, 6'h0D, 6'h0E, 6'h1E, 6'h16});

  // ****************************************
  // Decoder properties
  // ****************************************
  property p_idle; !vme_strobe_i |=> socket_select_n_o == 8'hFF && !mem_hit_o; endproperty
  a_idle: assert property (p_idle) else $error("select without strobe");
  property p_one; mem_hit_o |-> $onehot(~socket_select_n_o); endproperty
  a_one: assert property (p_one) else $error("not exactly one select");
  property p_hit; mem_hit_o == (socket_select_n_o != 8'hFF); endproperty
  a_hit: assert property (p_hit) else $error("hit flag disagrees");
  property p_lane;
    vme_strobe_i |=> !mem_hit_o || |(~socket_select_n_o & (8'h11 << $past(vme_addr_i[1:0])));
  endproperty
  a_lane: assert property (p_lane) else $error("wrong byte lane");
  property p_bad; bad |=> !mem_hit_o && !other_inhibit_o; endproperty
  a_bad: assert property (p_bad) else $error("unknown modifier decoded");
  property p_q1; m16 && men[1] && rq[0] |=> other_inhibit_o && socket_select_n_o[7:4] != 4'hF;
  endproperty
  a_q1: assert property (p_q1) else $error("modifier 16 missed quad 1");
  property p_q2; m1e && men[0] && rq[1] |=> other_inhibit_o && socket_select_n_o[3:0] != 4'hF;
  endproperty
  a_q2: assert property (p_q2) else $error("modifier 1E missed quad 2");
  property p_off; (m1e && !men[0]) || (m16 && !men[1]) |=> !other_inhibit_o && !mem_hit_o;
  endproperty
  a_off: assert property (p_off) else $error("disabled modifier decoded");
endmodule

// File: tb/vsd_vme_master.sv
// Model of the bus master presenting memory cycles to the decoder.
// Assumes its tasks are called from one bench process.
`timescale 1ns/10ps
module vsd_vme_master (
  input  wire         clock_i,
  output logic [31:0] vme_addr_o,
  output logic [5:0]  vme_am_o,
  output logic        vme_strobe_o
);
  // Idle lines at time zero
  initial begin
    vme_addr_o = 32'h0;
    vme_am_o = 6'h0;
    vme_strobe_o = 1'b0;
  end
  // Present and hold a cycle; return once the answer has settled
  task automatic present(input logic [31:0] a, input logic [5:0] m);
    @(posedge clock_i);
    vme_addr_o <= a;
    vme_am_o <= m;
    vme_strobe_o <= 1'b1;
    @(posedge clock_i);
    @(negedge clock_i);
  endtask
  // Released lines flip, so a stale value never decodes by luck
  task automatic release_bus();
    @(posedge clock_i);
    vme_strobe_o <= 1'b0;
    vme_addr_o <= ~vme_addr_o;
    vme_am_o <= ~vme_am_o;
  endtask
endmodule

// File: tb/testbench.sv
// Self-checking bench: strap sets, decode table, register bus.
// Assumes the decoder, bus master model and checker are compiled first.
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin mismatches++; \
  $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module testbench;
  typedef struct packed {logic [1:0] c; logic [31:0] a; logic [5:0] m; logic [7:0] s;
                         logic i;} vsd_vec_t;
  logic        clock_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic [1:0]  mod_en = 2'b11, rom_q = 2'b01, ram_q = 2'b01;
  logic        wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [3:0]  wb_adr = 4'h0, wb_sel = 4'hF;
  logic [2:0]  rom_sz = 3'h5;
  logic [31:0] wb_dat = 32'h0, rd;
  wire  [31:0] vme_addr, wb_dat_o;
  wire  [5:0]  vme_am;
  wire  [7:0]  sel_n;
  wire         vme_strobe, mem_hit, inhibit, wb_ack_o;
  int          mismatches = 0, cmp_count = 0, hits = 0;
  // Strap sets {ram quads, rom quads, modifier enables}: mixed, rom, rom no mod, ram
  logic [5:0]  cfg_tab [4] = '{6'b010111, 6'b001111, 6'b001100, 6'b111111};
  // Rom base FF0000 with 8K parts, ram base 0 with 2K parts: aligned, apart
  vsd_vec_t    v [25] = '{
    '{0, 32'h0, 6'h39, 8'hFE, 0}, '{0, 32'h1, 6'h3A, 8'hFD, 0},
    '{0, 32'h2, 6'h3D, 8'hFB, 0}, '{0, 32'h7, 6'h3E, 8'hF7, 0},
    '{0, 32'h2000, 6'h39, 8'hFF, 0}, '{0, 32'hFF0000, 6'h39, 8'hEF, 0},
    '{0, 32'hFF8003, 6'h39, 8'hFF, 0}, '{0, 32'h1, 6'h09, 8'hFD, 0},
    '{0, 32'h1000001, 6'h0A, 8'hFF, 0}, '{0, 32'hFFFF0002, 6'h0D, 8'hBF, 0},
    '{0, 32'hFFFF0003, 6'h0E, 8'h7F, 0}, '{0, 32'h0, 6'h3B, 8'hFF, 0},
    '{0, 32'h3, 6'h16, 8'h7F, 1}, '{0, 32'hFE0000, 6'h39, 8'hFF, 0},
    '{0, 32'hFF4001, 6'h39, 8'hDF, 0}, '{0, 32'h4000, 6'h39, 8'hFF, 0},
    '{1, 32'hFF8000, 6'h39, 8'hFE, 0}, '{1, 32'hFF7FFF, 6'h39, 8'h7F, 0},
    '{1, 32'h0, 6'h39, 8'hFF, 0}, '{1, 32'h1, 6'h1E, 8'hFD, 1},
    '{2, 32'h1, 6'h1E, 8'hFF, 0}, '{2, 32'h2, 6'h16, 8'hFF, 0},
    '{3, 32'h2000, 6'h39, 8'hEF, 0}, '{3, 32'hFF0000, 6'h39, 8'hFF, 0},
    '{3, 32'h3FFF, 6'h3A, 8'h7F, 0}};

  vsd_memory_decoder i_vsd_memory_decoder (.clock_i(clock_i), .arst_n_i(arst_n_i),
    .vme_addr_i(vme_addr), .vme_am_i(vme_am), .vme_strobe_i(vme_strobe),
    .eprom_base_low_straps_i(10'h000), .eprom_base_high_straps_i(8'h00),
    .ram_base_low_straps_i(10'h3FF), .ram_base_high_straps_i(8'hFF),
    .eprom_size_straps_i(rom_sz), .ram_size_straps_i(3'h7),
    .modifier_eprom_enable_straps_i(mod_en), .eprom_quad_enable_straps_i(rom_q),
    .ram_quad_enable_straps_i(ram_q), .socket_select_n_o(sel_n), .mem_hit_o(mem_hit),
    .other_inhibit_o(inhibit), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o));
  vsd_vme_master i_vsd_vme_master (.clock_i(clock_i), .vme_addr_o(vme_addr),
    .vme_am_o(vme_am), .vme_strobe_o(vme_strobe));

  // 10 MHz clock
  always #50 clock_i = ~clock_i;

  // ****************************************
  // Bus tasks and verdict
  // ****************************************
  // Classic cycle: hold until ack is sampled, then release for a cycle
  // No local limit; a missing ack is caught by the watchdog
  task automatic wb_xfer(input logic we, input logic [3:0] sel, input logic [3:0] adr,
                         input logic [31:0] wd, output logic [31:0] rdat);
    @(posedge clock_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_sel <= sel;
    wb_adr <= adr;
    wb_dat <= wd;
    do begin
      @(posedge clock_i);
    end while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Main sequence: decode table, then register access
  initial begin
    repeat (12) @(posedge clock_i);
    arst_n_i <= 1'b1;
    foreach (v[k]) begin
      @(posedge clock_i);
      {ram_q, rom_q, mod_en} <= cfg_tab[v[k].c];
      hits += (v[k].s != 8'hFF);
      i_vsd_vme_master.present(v[k].a, v[k].m);
      `CHK("select", v[k].s, sel_n)
      `CHK("hit", v[k].s != 8'hFF, mem_hit)
      `CHK("inhibit", v[k].i, inhibit)
      i_vsd_vme_master.release_bus();
    end
    wb_xfer(1'b0, 4'hF, 4'h0, 32'h0, rd);
    `CHK("ctrl", 32'h1, rd)
    // Write without the low byte select must be dropped
    wb_xfer(1'b1, 4'hE, 4'h0, 32'h0, rd);
    wb_xfer(1'b0, 4'hF, 4'h0, 32'h0, rd);
    `CHK("sel gate", 32'h1, rd)
    wb_xfer(1'b1, 4'hF, 4'h0, 32'h0, rd);
    i_vsd_vme_master.present(32'h2000, 6'h39);
    `CHK("disabled", 8'hFF, sel_n)
    i_vsd_vme_master.release_bus();
    wb_xfer(1'b1, 4'hF, 4'h0, 32'h1, rd);
    wb_xfer(1'b0, 4'hF, 4'h4, 32'h0, rd);
    `CHK("sizes", 6'h02, rd[15:10])
    // Last strobe was the disabled one: a miss, no select, not a modifier access
    `CHK("status", 10'h200, rd[9:0])
    rom_sz <= 3'h4;
    wb_xfer(1'b0, 4'hF, 4'h4, 32'h0, rd);
    `CHK("rom size", 3'h3, rd[12:10])
    wb_xfer(1'b0, 4'hF, 4'h8, 32'h0, rd);
    `CHK("hits", hits, rd)
    wb_xfer(1'b1, 4'hF, 4'h8, 32'h0, rd);
    wb_xfer(1'b0, 4'hF, 4'h8, 32'h0, rd);
    `CHK("count", 32'h0, rd)
    wb_xfer(1'b0, 4'hF, 4'hC, 32'h0, rd);
    `CHK("unmapped", 32'h0, rd)
    wrap_up();
  end
  // Watchdog well beyond the expected 150 or so cycles
  initial begin
    repeat (3000) @(posedge clock_i);
    mismatches++;
    wrap_up();
  end
endmodule
bind vsd_memory_decoder vsd_decoder_checker i_chk (.clock_i(clock_i), .arst_n_i(arst_n_i),
  .vme_addr_i(vme_addr_i), .vme_am_i(vme_am_i), .vme_strobe_i(vme_strobe_i),
  .modifier_eprom_enable_straps_i(modifier_eprom_enable_straps_i),
  .eprom_quad_enable_straps_i(eprom_quad_enable_straps_i),
  .socket_select_n_o(socket_select_n_o), .mem_hit_o(mem_hit_o),
  .other_inhibit_o(other_inhibit_o));
